// ### rtl/tccc_top.sv
// timer channel: clock source, counter clear and capture/compare control
//
// Contract
// (RULE_01) clock select register bits 7 and 6 always read as one.
// (RULE_02) edge field 00 rising, 01 falling, 10 both edges of external clock.
// (RULE_03) edge field ignored while an internal divided clock is chosen.
// (RULE_04) source codes 0000..1100 pick clk/1 up to clk/4096; reset clk/1.
// (RULE_05) codes 1101, 1110, 1111 pick external clock inputs one to three.
// (RULE_06) clear/capture register bit 7 always reads as one.
// (RULE_07) clear field 000, the reset value, never clears the counter.
// (RULE_08) clear codes 001..011 clear along with the paired timer's clear.
// (RULE_09) code 100 clears on general reg one event, 110 on reg three.
// (RULE_10) code 101 clears on dedicated two match, 111 on dedicated four.
// (RULE_11) general reg clear: match in compare use, capture in capture use.
// (RULE_12) general reg two field: 00 compare, 01 rise, 10 fall, 11 both.
// (RULE_13) general reg one field, bits 1:0: 00 compare, else capture edge.
// (RULE_14) aux capture register bits 7 to 4 always read as one.
// (RULE_15) general reg four field, aux bits 3:2: 00 compare, else capture.
// (RULE_16) general reg three field, aux bits 1:0: 00 compare, else capture.
// (RULE_17) reset zeroes all capture fields; non-zero field means capture use.
// (RULE_18) capture latches counter on valid edge; compare matches equality.
// (RULE_19) counter is 16 bits, whole-word read/write, zero after reset.
// (RULE_20) external edge code 11 counts on both edges.
`timescale 1ns/10ps
`include "tccc_cfg.svh"
module tccc_top #(
  parameter int CNT_W = `TCCC_CNT_W,
  parameter int DIV_W = `TCCC_DIV_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire tccc_pkg::tccc_addr_t reg_addr,
  input wire tccc_pkg::tccc_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output tccc_pkg::tccc_data_t reg_rdata,
  input wire logic ext_clock_in_one,
  input wire logic ext_clock_in_two,
  input wire logic ext_clock_in_three,
  input wire logic [`TCCC_N_GR-1:0] capture_in,
  input wire logic pair_clear_in,
  output logic [CNT_W-1:0] channel_counter_o,
  output logic [`TCCC_N_GR-1:0] cmp_match_o,
  output logic [1:0] dcmp_match_o,
  output logic [`TCCC_N_GR-1:0] capture_o,
  output logic counter_clear_o
);
  import tccc_pkg::*;

  localparam int NGR = `TCCC_N_GR;
  localparam int NEXT = `TCCC_N_EXT;

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  logic [1:0] edge_sel_r;
  logic [3:0] clk_src_r;
  logic [2:0] clear_src_r;
  tccc_cap_mode_t cap_mode_r [NGR];
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] gr_r [NGR];
  logic [CNT_W-1:0] dcmp_r [2];
  logic [7:0] status_r;

  logic wr_clk_sel;
  logic wr_clr_cap;
  logic wr_aux_cap;
  logic wr_cnt;
  logic wr_status;

  assign wr_clk_sel = reg_wr && (reg_addr == `TCCC_OFS_CLK_SEL);
  assign wr_clr_cap = reg_wr && (reg_addr == `TCCC_OFS_CLR_CAP);
  assign wr_aux_cap = reg_wr && (reg_addr == `TCCC_OFS_AUX_CAP);
  assign wr_cnt = reg_wr && (reg_addr == `TCCC_OFS_COUNTER);
  assign wr_status = reg_wr && (reg_addr == `TCCC_OFS_STATUS);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      edge_sel_r <= `TCCC_EDGE_RESET;
      clk_src_r <= `TCCC_SRC_RESET; // RULE_04
    end else if (wr_clk_sel) begin
      edge_sel_r <= reg_wdata[`TCCC_EDGE_LSB +: 2];
      clk_src_r <= reg_wdata[`TCCC_SRC_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clear_src_r <= `TCCC_CLR_RESET; // RULE_07
    end else if (wr_clr_cap) begin
      clear_src_r <= reg_wdata[`TCCC_CLR_LSB +: 3];
    end
  end

  // general regs one/two live in the clear/capture register, three/four
  // in the aux register; both registers keep the hi pair in bits 3:2
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NGR; i++) begin
        cap_mode_r[i] <= tccc_cap_mode_t'(`TCCC_CAP_RESET); // RULE_17
      end
    end else begin
      if (wr_clr_cap) begin
        cap_mode_r[0] <= tccc_cap_mode_t'(
          reg_wdata[`TCCC_CAP_LO_LSB +: 2]); // RULE_13
        cap_mode_r[1] <= tccc_cap_mode_t'(
          reg_wdata[`TCCC_CAP_HI_LSB +: 2]); // RULE_12
      end
      if (wr_aux_cap) begin
        cap_mode_r[2] <= tccc_cap_mode_t'(
          reg_wdata[`TCCC_CAP_LO_LSB +: 2]); // RULE_16
        cap_mode_r[3] <= tccc_cap_mode_t'(
          reg_wdata[`TCCC_CAP_HI_LSB +: 2]); // RULE_15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and prescaler

  logic [DIV_W:0] tap_tick;
  logic [NEXT-1:0] ext_rise;
  logic [NEXT-1:0] ext_fall;
  logic [NGR-1:0] cap_rise;
  logic [NGR-1:0] cap_fall;

  tccc_prescaler #(
    .DIV_W(DIV_W)
  ) u_presc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tap_tick(tap_tick)
  );

  tccc_edge_det #(
    .N(NEXT)
  ) u_ext_edge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in({ext_clock_in_three, ext_clock_in_two, ext_clock_in_one}),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  tccc_edge_det #(
    .N(NGR)
  ) u_cap_edge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(capture_in),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // count tick selection

  logic count_tick;
  logic [1:0] ext_idx;
  logic ext_hit;

  // internal codes would index past the three pins, so park them on pin one
  assign ext_idx = (clk_src_r < `TCCC_EXT_SRC_BASE) ? 2'b00 :
    2'(clk_src_r - `TCCC_EXT_SRC_BASE);

  always_comb begin
    ext_hit = 1'b0;
    unique case (edge_sel_r)
      2'b00: ext_hit = ext_rise[ext_idx]; // RULE_02
      2'b01: ext_hit = ext_fall[ext_idx]; // RULE_02
      // 11 is undefined; treat as both edges so counting stays predictable
      2'b10, 2'b11: ext_hit = ext_rise[ext_idx] | ext_fall[ext_idx]; // RULE_20
    endcase
  end

  always_comb begin
    if (clk_src_r < `TCCC_EXT_SRC_BASE) begin
      count_tick = tap_tick[clk_src_r]; // RULE_03 RULE_04
    end else begin
      count_tick = ext_hit; // RULE_05
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general registers: capture or compare per register

  logic [NGR-1:0] cap_evt;
  logic [NGR-1:0] cmp_eq;
  logic [NGR-1:0] gr_event;
  logic [1:0] dcmp_eq;

  genvar g;
  generate
    for (g = 0; g < NGR; g++) begin : g_gr
      logic is_cap;
      logic [1:0] mode_bits;
      logic wr_gr;

      assign mode_bits = cap_mode_r[g];
      assign is_cap = (cap_mode_r[g] != TCCC_CAP_OFF); // RULE_17
      // bit 0 enables rising, bit 1 falling, both set gives both edges
      assign cap_evt[g] = is_cap && ((mode_bits[0] && cap_rise[g]) ||
        (mode_bits[1] && cap_fall[g])); // RULE_12 RULE_13 RULE_15 RULE_16
      assign cmp_eq[g] = !is_cap && (cnt_r == gr_r[g]); // RULE_18
      // compare clear happens on the tick that would leave the match value
      assign gr_event[g] = is_cap ? cap_evt[g] :
        (cmp_eq[g] && count_tick); // RULE_11
      assign wr_gr = reg_wr &&
        (reg_addr == `TCCC_ADDR_W'(`TCCC_OFS_GR_ONE + g));

      // a capture in the same cycle as a software write wins
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          gr_r[g] <= `TCCC_GR_RESET;
        end else if (cap_evt[g]) begin
          gr_r[g] <= cnt_r; // RULE_18
        end else if (wr_gr) begin
          gr_r[g] <= reg_wdata[CNT_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dcmp_r[0] <= `TCCC_GR_RESET;
      dcmp_r[1] <= `TCCC_GR_RESET;
    end else begin
      if (reg_wr && reg_addr == `TCCC_OFS_DCMP_TWO) begin
        dcmp_r[0] <= reg_wdata[CNT_W-1:0];
      end
      if (reg_wr && reg_addr == `TCCC_OFS_DCMP_FOUR) begin
        dcmp_r[1] <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  assign dcmp_eq[0] = (cnt_r == dcmp_r[0]);
  assign dcmp_eq[1] = (cnt_r == dcmp_r[1]);

  ////////////////////////////////////////////////////////////////////////////
  // counter clear source and counter

  logic clear_now;

  always_comb begin
    unique case (clear_src_r)
      `TCCC_CLR_NONE: clear_now = 1'b0; // RULE_07
      `TCCC_CLR_GR_ONE: clear_now = gr_event[0]; // RULE_09
      `TCCC_CLR_DCMP_TWO: clear_now = dcmp_eq[0] && count_tick; // RULE_10
      `TCCC_CLR_GR_THREE: clear_now = gr_event[2]; // RULE_09
      `TCCC_CLR_DCMP_FOUR: clear_now = dcmp_eq[1] && count_tick; // RULE_10
      default: clear_now = pair_clear_in; // RULE_08
    endcase
  end

  // software write has priority so a written value is never lost
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_r <= `TCCC_CNT_RESET; // RULE_19
    end else if (wr_cnt) begin
      cnt_r <= reg_wdata[CNT_W-1:0]; // RULE_19
    end else if (clear_now) begin
      cnt_r <= '0;
    end else if (count_tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status: sticky, write one to clear, a new event beats the clear

  // software polls these bits; the block itself raises no interrupt
  logic [7:0] status_set;

  assign status_set = {1'b0, counter_clear_o, dcmp_match_o,
    capture_o | cmp_match_o};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      status_r <= 8'h00;
    end else begin
      status_r <= (status_r & ~(wr_status ? reg_wdata[7:0] : 8'h00)) |
        status_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmp_match_o <= '0;
      dcmp_match_o <= '0;
      capture_o <= '0;
      counter_clear_o <= 1'b0;
    end else begin
      cmp_match_o <= cmp_eq; // RULE_18
      dcmp_match_o <= dcmp_eq;
      capture_o <= cap_evt;
      counter_clear_o <= clear_now;
    end
  end

  assign channel_counter_o = cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // register read, data one cycle after the strobe

  tccc_data_t rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `TCCC_OFS_CLK_SEL: rd_mux = {8'h00, `TCCC_CLK_SEL_ONES,
        edge_sel_r, clk_src_r}; // RULE_01
      `TCCC_OFS_CLR_CAP: rd_mux = {8'h00, `TCCC_CLR_CAP_ONES, clear_src_r,
        2'(cap_mode_r[1]), 2'(cap_mode_r[0])}; // RULE_06
      `TCCC_OFS_AUX_CAP: rd_mux = {8'h00, `TCCC_AUX_CAP_ONES,
        2'(cap_mode_r[3]), 2'(cap_mode_r[2])}; // RULE_14
      `TCCC_OFS_COUNTER: rd_mux = cnt_r; // RULE_19
      `TCCC_OFS_GR_ONE: rd_mux = gr_r[0];
      `TCCC_OFS_GR_TWO: rd_mux = gr_r[1];
      `TCCC_OFS_GR_THREE: rd_mux = gr_r[2];
      `TCCC_OFS_GR_FOUR: rd_mux = gr_r[3];
      `TCCC_OFS_DCMP_TWO: rd_mux = dcmp_r[0];
      `TCCC_OFS_DCMP_FOUR: rd_mux = dcmp_r[1];
      `TCCC_OFS_STATUS: rd_mux = {8'h00, status_r};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ### shared/tccc_cfg.svh
// register offsets, field positions, reset values and sizes of the channel
`ifndef TCCC_CFG_SVH
`define TCCC_CFG_SVH

`define TCCC_ADDR_W 8
`define TCCC_DATA_W 16
`define TCCC_CNT_W 16
`define TCCC_DIV_W 12
`define TCCC_N_GR 4
`define TCCC_N_EXT 3

`define TCCC_OFS_CLK_SEL 8'h00
`define TCCC_OFS_CLR_CAP 8'h01
`define TCCC_OFS_AUX_CAP 8'h02
`define TCCC_OFS_COUNTER 8'h03
`define TCCC_OFS_GR_ONE 8'h04
`define TCCC_OFS_GR_TWO 8'h05
`define TCCC_OFS_GR_THREE 8'h06
`define TCCC_OFS_GR_FOUR 8'h07
`define TCCC_OFS_DCMP_TWO 8'h08
`define TCCC_OFS_DCMP_FOUR 8'h09
`define TCCC_OFS_STATUS 8'h0a

`define TCCC_EDGE_LSB 4
`define TCCC_SRC_LSB 0
`define TCCC_CLR_LSB 4
`define TCCC_CAP_HI_LSB 2
`define TCCC_CAP_LO_LSB 0

`define TCCC_CLK_SEL_ONES 2'b11
`define TCCC_CLR_CAP_ONES 1'b1
`define TCCC_AUX_CAP_ONES 4'hf

`define TCCC_SRC_RESET 4'h0
`define TCCC_EDGE_RESET 2'b00
`define TCCC_CLR_RESET 3'b000
`define TCCC_CAP_RESET 2'b00
`define TCCC_CNT_RESET 16'h0000
`define TCCC_GR_RESET 16'hffff
`define TCCC_EXT_SRC_BASE 4'hd

`define TCCC_CLR_NONE 3'b000
`define TCCC_CLR_GR_ONE 3'b100
`define TCCC_CLR_DCMP_TWO 3'b101
`define TCCC_CLR_GR_THREE 3'b110
`define TCCC_CLR_DCMP_FOUR 3'b111

`endif

// ### shared/tccc_pkg.sv
// types shared by the timer channel clock/clear/capture logic
`include "tccc_cfg.svh"
package tccc_pkg;
  typedef logic [`TCCC_ADDR_W-1:0] tccc_addr_t;
  typedef logic [`TCCC_DATA_W-1:0] tccc_data_t;
  typedef logic [`TCCC_CNT_W-1:0] tccc_cnt_t;
  typedef enum logic [1:0] {
    TCCC_CAP_OFF,
    TCCC_CAP_RISE,
    TCCC_CAP_FALL,
    TCCC_CAP_BOTH
  } tccc_cap_mode_t;
endpackage

// ### rtl/tccc_prescaler.sv
// free-running divider giving one-cycle ticks at clk/1 .. clk/2**DIV_W
`timescale 1ns/10ps
`include "tccc_cfg.svh"
module tccc_prescaler #(
  parameter int DIV_W = `TCCC_DIV_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  output logic [DIV_W:0] tap_tick
);
  import tccc_pkg::*;
  logic [DIV_W-1:0] div_r;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k <= DIV_W; k++) begin : g_tap
      if (k == 0) begin : g_full
        always_ff @(posedge ref_clk) begin
          tap_tick[k] <= rstn;
        end
      end else begin : g_div
        // tap k fires once every 2**k cycles
        always_ff @(posedge ref_clk) begin
          if (!rstn) begin
            tap_tick[k] <= 1'b0;
          end else begin
            tap_tick[k] <= &div_r[k-1:0];
          end
        end
      end
    end
  endgenerate
endmodule

// ### rtl/tccc_edge_det.sv
// two-flop synchroniser and edge detector for N pin inputs
`timescale 1ns/10ps
`include "tccc_cfg.svh"
module tccc_edge_det #(
  parameter int N = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  import tccc_pkg::*;
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      rise <= '0;
      fall <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise <= sync_r & ~prev_r;
      fall <= ~sync_r & prev_r;
    end
  end
endmodule

// ### testbench/tccc_assertions.sv
// concurrent checks on the timer channel top-level ports
`timescale 1ns/10ps
`include "tccc_cfg.svh"
module tccc_checker #(
  parameter int CNT_W = `TCCC_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire tccc_pkg::tccc_addr_t reg_addr,
  input wire tccc_pkg::tccc_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire tccc_pkg::tccc_data_t reg_rdata,
  input wire logic pair_clear_in,
  input wire logic [CNT_W-1:0] channel_counter_o,
  input wire logic [`TCCC_N_GR-1:0] capture_o,
  input wire logic counter_clear_o
);
  import tccc_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // shadow of the clear field, so clear checks know the chosen source
  logic [2:0] clr_src_r;
  logic cnt_wr;
  assign cnt_wr = reg_wr && reg_addr == `TCCC_OFS_COUNTER;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clr_src_r <= `TCCC_CLR_RESET;
    end else if (reg_wr && reg_addr == `TCCC_OFS_CLR_CAP) begin
      clr_src_r <= reg_wdata[6:4];
    end
  end
  //////////////////////////////////////////////////////////////
  sequence rd_at_s(tccc_addr_t a);
    reg_rd && reg_addr == a;
  endsequence
  sequence pair_clr_s;
    pair_clear_in && !cnt_wr && !clr_src_r[2] && |clr_src_r;
  endsequence
  rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read");
  clk_sel_ones_a:
    assert property (rd_at_s(`TCCC_OFS_CLK_SEL) |=> reg_rdata[7:6] == 2'b11)
    else $error("clock select top bits not one");
  clr_cap_ones_a:
    assert property (rd_at_s(`TCCC_OFS_CLR_CAP) |=> reg_rdata[7] == 1'b1)
    else $error("clear control top bit not one");
  aux_cap_ones_a:
    assert property (rd_at_s(`TCCC_OFS_AUX_CAP) |=> reg_rdata[7:4] == 4'hf)
    else $error("aux control top bits not one");
  cnt_reset_a:
    assert property ($rose(rstn) |-> channel_counter_o == '0)
    else $error("counter not zero after reset");
  cnt_step_a:
    assert property ($changed(channel_counter_o) && !$past(cnt_wr) |->
      channel_counter_o == $past(channel_counter_o) + 1'b1 ||
      channel_counter_o == '0)
    else $error("counter moved by other than one");
  pair_clear_a:
    assert property (pair_clr_s |=> channel_counter_o == '0 && counter_clear_o)
    else $error("paired clear did not clear counter");
  no_clear_a:
    assert property (clr_src_r == 3'b000 && $past(clr_src_r) == 3'b000 |->
      !counter_clear_o)
    else $error("counter cleared with no clear source");
  clear_zero_a:
    assert property (counter_clear_o && !$past(cnt_wr) |->
      channel_counter_o == '0)
    else $error("clear pulse with counter not zero");
  cap_pulse_a:
    assert property (|capture_o |=> (capture_o & $past(capture_o)) == '0)
    else $error("capture pulse longer than one cycle");
endmodule
bind tccc_top tccc_checker #(.CNT_W(CNT_W)) i_chk (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pair_clear_in(pair_clear_in),
  .channel_counter_o(channel_counter_o), .capture_o(capture_o),
  .counter_clear_o(counter_clear_o)
);

// ### testbench/tccc_pin_model.sv
// behavioural sources for the external clock and capture pins
`timescale 1ns/10ps
`include "tccc_cfg.svh"
module tccc_pin_model (
  output logic ext_clock_in_one,
  output logic ext_clock_in_two,
  output logic ext_clock_in_three,
  output logic [`TCCC_N_GR-1:0] capture_in
);
  logic [2:0] ext = 3'b000;
  initial begin
    capture_in = '0;
  end
  assign ext_clock_in_one = ext[0];
  assign ext_clock_in_two = ext[1];
  assign ext_clock_in_three = ext[2];
  //////////////////////////////////////////////////////////////
  // pin j gives j+1 pulses, so the count shows which pin was used;
  // pins rest low between bursts so no stray edge is counted
  task automatic burst();
    // step off the clock edge so no pin moves on a sampling edge
    #1;
    for (int j = 0; j < 3; j++) begin
      repeat (j + 1) begin
        ext[j] = 1'b1;
        #43;
        ext[j] = 1'b0;
        #47;
      end
    end
  endtask
  // levels held well past the two-flop synchroniser
  task automatic cap_pulse(input int g);
    #1;
    capture_in[g] = 1'b1;
    #53;
    capture_in[g] = 1'b0;
    #60;
  endtask
endmodule

// ### testbench/timer_chan_clock_clear_capture_cfg_tb.sv
// self-checking bench for the timer channel clock/clear/capture block
`timescale 1ns/10ps
`include "tccc_cfg.svh"
module timer_chan_clock_clear_capture_cfg_tb;
  import tccc_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  tccc_addr_t reg_addr = '0;
  tccc_data_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pair_clear_in = 1'b0;
  tccc_data_t reg_rdata;
  logic ck1, ck2, ck3;
  logic [3:0] cap_in, cap_out, cmp_m;
  logic [1:0] dcmp_m;
  int errors = 0;
  int n_compared = 0;
  int caps[4] = '{0, 0, 0, 0};
  always #2.5 ref_clk = ~ref_clk;
  tccc_pin_model i_pins (.ext_clock_in_one(ck1), .ext_clock_in_two(ck2),
    .ext_clock_in_three(ck3), .capture_in(cap_in));
  tccc_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_clock_in_one(ck1),
    .ext_clock_in_two(ck2), .ext_clock_in_three(ck3),
    .capture_in(cap_in), .pair_clear_in(pair_clear_in),
    .channel_counter_o(), .cmp_match_o(cmp_m), .dcmp_match_o(dcmp_m),
    .capture_o(cap_out), .counter_clear_o());
  always @(posedge ref_clk) begin
    for (int g = 0; g < 4; g++) begin
      caps[g] += int'(cap_out[g] === 1'b1);
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic chk(input tccc_data_t seen, input tccc_data_t exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input tccc_addr_t a, input tccc_data_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe; taken mid-cycle
  task automatic rd(input tccc_addr_t a, output tccc_data_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    tccc_data_t rv;
    tccc_addr_t a;
    static tccc_addr_t ra[4] = '{8'h00, 8'h01, 8'h02, 8'h20};
    static tccc_data_t re[4] = '{16'h00c0, 16'h0080, 16'h00f0, 16'h0000};
    static tccc_addr_t ca[4] = '{8'h04, 8'h08, 8'h06, 8'h09};
    static tccc_data_t ne[4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0002};
    cyc(8);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], rv);
      chk(rv, re[i]);
      wr(ra[i], 16'h00ff);
      rd(ra[i], rv);
      chk(rv, i < 3 ? 16'h00ff : 16'h0000);
      wr(ra[i], 16'h0000);
      rd(ra[i], rv);
      chk(rv, re[i]);
    end
    $display("test register access finished");
    // edge field set to junk: must not matter for divided clocks
    for (int k = 0; k <= 12; k++) begin
      wr(`TCCC_OFS_CLK_SEL, 16'(k) | 16'((k % 4) << 4));
      wr(`TCCC_OFS_COUNTER, 16'h0000);
      cyc(4 << k);
      rd(`TCCC_OFS_COUNTER, rv);
      chk(16'(rv inside {[4:6]}), 16'h0001);
    end
    $display("test divided clocks finished");
    for (int p = 0; p < 3; p++) begin
      for (int e = 0; e < 4; e++) begin
        wr(`TCCC_OFS_CLK_SEL, 16'(13 + p) | 16'(e << 4));
        wr(`TCCC_OFS_COUNTER, 16'h0000);
        i_pins.burst();
        cyc(8);
        rd(`TCCC_OFS_COUNTER, rv);
        chk(rv, 16'((p + 1) * (e > 1 ? 2 : 1)));
      end
    end
    $display("test external clocks finished");
    // idle pin one as source holds the counter still for capture
    wr(`TCCC_OFS_CLK_SEL, 16'h000d);
    for (int g = 0; g < 4; g++) begin
      a = g < 2 ? `TCCC_OFS_CLR_CAP : `TCCC_OFS_AUX_CAP;
      for (int m = 0; m < 4; m++) begin
        wr(a, 16'(m << (2 * (g % 2))));
        wr(`TCCC_OFS_COUNTER, 16'h1230 + 16'(4 * g + m));
        caps[g] = 0;
        i_pins.cap_pulse(g);
        cyc(8);
        chk(16'(caps[g]), ne[m]);
        rd(tccc_addr_t'(`TCCC_OFS_GR_ONE + g), rv);
        chk(rv, m ? 16'h1230 + 16'(4 * g + m) : 16'hffff);
      end
      wr(a, 16'h0000);
      wr(tccc_addr_t'(`TCCC_OFS_GR_ONE + g), 16'hffff);
    end
    $display("test capture edges finished");
    // counter held still: only general two and dedicated two may match
    wr(`TCCC_OFS_COUNTER, 16'h0100);
    wr(`TCCC_OFS_GR_TWO, 16'h0100);
    wr(`TCCC_OFS_DCMP_TWO, 16'h0100);
    cyc(2);
    #1;
    chk(16'({dcmp_m, cmp_m}), 16'h0012);
    wr(`TCCC_OFS_GR_TWO, 16'hffff);
    wr(`TCCC_OFS_DCMP_TWO, 16'hffff);
    for (int c = 0; c < 4; c++) begin
      wr(`TCCC_OFS_CLR_CAP, 16'(c << 4));
      wr(`TCCC_OFS_COUNTER, 16'h0055);
      @(posedge ref_clk);
      pair_clear_in <= 1'b1;
      @(posedge ref_clk);
      pair_clear_in <= 1'b0;
      rd(`TCCC_OFS_COUNTER, rv);
      chk(rv, c ? 16'h0000 : 16'h0055);
    end
    // only the selected register may clear: others stay at ffff
    wr(`TCCC_OFS_CLK_SEL, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(ca[c], 16'h0005);
      wr(`TCCC_OFS_CLR_CAP, 16'((4 + c) << 4));
      wr(`TCCC_OFS_COUNTER, 16'h0000);
      cyc(30);
      rd(`TCCC_OFS_COUNTER, rv);
      chk(16'(rv <= 16'h0005), 16'h0001);
      wr(ca[c], 16'hffff);
    end
    wr(`TCCC_OFS_CLR_CAP, 16'h0041);
    wr(`TCCC_OFS_COUNTER, 16'h4000);
    i_pins.cap_pulse(0);
    rd(`TCCC_OFS_COUNTER, rv);
    chk(16'(rv < 16'h4000), 16'h0001);
    $display("test clear sources finished");
    tally_and_finish();
  end
  // tests take about 36000 cycles; allow over twice that, 80000 cycles
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule
